// ==== ucm_pkg.sv ====
// Constants for the upconverter channel back end: delay, mixer and oscillator.
// Assumes a single 200 MHz transmit clock and an AXI4-Lite register master.
package ucm_pkg;
	localparam int unsigned CLK_HZ   = 200_000_000;
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned DIN_W    = 18;
	localparam int unsigned NCO_W    = 20;
	localparam int unsigned OUT_W    = 21;
	localparam int unsigned ACC_W    = 32;
	localparam int unsigned POFS_W   = 16;
	localparam int unsigned DITH_W   = 5;
	localparam int unsigned DITH_LSB = 21;
	localparam int unsigned LUT_AW   = 6;
	localparam int unsigned DLY_AW   = 6;
	localparam int unsigned NSYNC    = 8;
	localparam int unsigned MIX_W    = 39;
	localparam int unsigned SH_GAIN  = 17;
	localparam int unsigned SH_NOGN  = 18;

	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_FINE    = 8'h04;
	localparam logic [7:0] OFS_COARSE  = 8'h08;
	localparam logic [7:0] OFS_SSEL    = 8'h0C;
	localparam logic [7:0] OFS_FREQ_LO = 8'h10;
	localparam logic [7:0] OFS_FREQ_HI = 8'h14;
	localparam logic [7:0] OFS_PHASE   = 8'h18;
	localparam logic [7:0] OFS_STATUS  = 8'h1C;

	localparam int unsigned CTRL_CDMA  = 0;
	localparam int unsigned CTRL_GAIN  = 1;
	localparam int unsigned CTRL_DITH  = 2;
	localparam int unsigned CTRL_DECIM = 4;
	localparam int unsigned FINE_B     = 4;
	localparam int unsigned COARSE_B   = 8;
	localparam int unsigned SSEL_FINE  = 0;
	localparam int unsigned SSEL_CRS   = 4;
	localparam int unsigned SSEL_NCO   = 8;
	localparam int unsigned SSEL_DITH  = 12;
	localparam int unsigned SSEL_FREQ  = 16;
	localparam int unsigned SSEL_PHASE = 20;
	localparam int unsigned STAT_CNT   = 0;
	localparam int unsigned STAT_WPTR  = 8;
	localparam int unsigned STAT_ACC   = 16;

	localparam logic [31:0] CTRL_MASK  = 32'h0000_0077;
	localparam logic [31:0] FINE_MASK  = 32'h0000_0077;
	localparam logic [31:0] CRS_MASK   = 32'h0000_3F3F;
	localparam logic [31:0] SSEL_MASK  = 32'h0077_7777;
	localparam logic [31:0] HALF_MASK  = 32'h0000_FFFF;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0002;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [6:0]  DLY_BASE    = 7'h03;
	localparam logic [6:0]  DLY_WRAP    = 7'h40;
	localparam logic [5:0]  CRS_NEG2    = 6'h3E;
	localparam logic [14:0] DITH_SEED   = 15'h0001;

	// Quarter sine, 17 points from 0 to 90 degrees, full scale 2^19-1
	localparam logic [19:0] SIN_Q [17] = '{
		20'h00000, 20'h0C8BD, 20'h18F8C, 20'h25281, 20'h30FBC, 20'h3C56C,
		20'h471CF, 20'h5133D, 20'h5A828, 20'h62F20, 20'h6A6DA, 20'h70E2D,
		20'h7641C, 20'h7A7D1, 20'h7D8A5, 20'h7F623, 20'h7FFFF};
endpackage

// ==== ucm_chan.sv ====
// Channel delay, complex mixer and oscillator of one upconverter channel.
// Assumes full-rate baseband input each clock and sync pulses synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module ucm_chan #(
	parameter int unsigned CHAN_INDEX = 0
) (
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// AXI4-Lite write
	input  wire logic [ucm_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [ucm_pkg::DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ucm_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [ucm_pkg::DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Sync sources
	input  wire logic [ucm_pkg::NSYNC-1:0]     sync_in,
	// Baseband from the interpolation filters
	input  wire logic [ucm_pkg::DIN_W-1:0]     din_i_a,
	input  wire logic [ucm_pkg::DIN_W-1:0]     din_q_a,
	input  wire logic [ucm_pkg::DIN_W-1:0]     din_i_b,
	input  wire logic [ucm_pkg::DIN_W-1:0]     din_q_b,
	// Mixed output to the sum chain
	output logic [ucm_pkg::OUT_W-1:0]          out_i_a,
	output logic [ucm_pkg::OUT_W-1:0]          out_q_a,
	output logic                               out_valid_a,
	output logic [ucm_pkg::OUT_W-1:0]          out_i_b,
	output logic [ucm_pkg::OUT_W-1:0]          out_q_b,
	output logic                               out_valid_b
);
	import ucm_pkg::*;

	// Pair offset keeps sum-chain pipeline aligned across channel pairs
	localparam logic [6:0] PAIR_EXTRA = 7'((CHAN_INDEX / 2) * 2);

	typedef struct packed {
		logic                               awready;
		logic                               wready;
		logic                               aw_held;
		logic                               w_held;
		logic [ADDR_W-1:0]                  awaddr;
		logic [DATA_W-1:0]                  wdata;
		logic [3:0]                         wstrb;
		logic                               bvalid;
		logic [1:0]                         bresp;
		logic                               arready;
		logic                               rvalid;
		logic [1:0]                         rresp;
		logic [DATA_W-1:0]                  rdata;
		logic [31:0]                        ctrl;
		logic [31:0]                        fine;
		logic [31:0]                        coarse;
		logic [31:0]                        ssel;
		logic [15:0]                        freq_lo;
		logic [15:0]                        freq_hi;
		logic [POFS_W-1:0]                  pofs;
		logic [2:0]                         decim_act;
		logic [1:0][2:0]                    fine_act;
		logic [1:0][5:0]                    crs_act;
		logic [ACC_W-1:0]                   freq_act;
		logic [POFS_W-1:0]                  pofs_act;
		logic [2:0]                         cnt;
		logic [ACC_W-1:0]                   acc;
		logic [14:0]                        lfsr;
		logic [1:0][DLY_AW-1:0]             wptr;
		logic [1:0][63:0][2*DIN_W-1:0]      mem;
		logic [1:0][OUT_W-1:0]              out_i;
		logic [1:0][OUT_W-1:0]              out_q;
		logic [1:0]                         out_valid;
	} ucm_state_s;

	ucm_state_s r_reg;
	ucm_state_s r_next;

	logic [1:0][DIN_W-1:0]  din_i;
	logic [1:0][DIN_W-1:0]  din_q;
	logic [1:0][2:0]        phase_sel;
	logic [1:0][6:0]        lat;
	logic [1:0]             strobe;
	logic                   cdma;
	logic                   sy_fine;
	logic                   sy_crs;
	logic                   sy_nco;
	logic                   sy_dith;
	logic                   sy_freq;
	logic                   sy_phase;
	logic [DITH_W-1:0]      dither;
	logic [ACC_W-1:0]       phase_sum;
	logic [2*NCO_W-1:0]     cs;
	logic [2:0]             dec_field;
	logic [2:0]             decim_eff;
	logic [31:0]            stat_word;

	assign din_i = {din_i_b, din_i_a};
	assign din_q = {din_q_b, din_q_a};
	assign cdma  = r_reg.ctrl[CTRL_CDMA];

	function automatic logic [31:0] merge_be(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] v;
		v = o;
		for (int k = 0; k < 4; k++) begin
			if (be[k]) begin
				v[8*k +: 8] = d[8*k +: 8];
			end
		end
		return v;
	endfunction

	// Capture phase that realises the documented fine shifts for 1, 2, 4 and 8
	function automatic logic [2:0] fine_phase(input logic [2:0] dec, input logic [2:0] f);
		logic [2:0] ph;
		ph = 3'h0;
		if (f == 3'h0) begin
			ph = 3'h0;
		end else if (f == dec) begin
			ph = 3'h1;
		end else begin
			ph = 3'(dec + 3'h1 - f);
		end
		return ph & dec;
	endfunction

	// Cosine in upper half, sine in lower half
	function automatic logic [2*NCO_W-1:0] cos_sin(input logic [LUT_AW-1:0] a);
		logic [3:0]       i;
		logic [NCO_W-1:0] lo;
		logic [NCO_W-1:0] hi;
		logic [NCO_W-1:0] c;
		logic [NCO_W-1:0] s;
		i  = a[3:0];
		lo = SIN_Q[5'(i)];
		hi = SIN_Q[5'h10 - 5'(i)];
		c  = '0;
		s  = '0;
		unique case (a[5:4])
			2'h0: begin
				c = hi;
				s = lo;
			end
			2'h1: begin
				c = -lo;
				s = hi;
			end
			2'h2: begin
				c = -hi;
				s = -lo;
			end
			2'h3: begin
				c = lo;
				s = -hi;
			end
		endcase
		return {c, s};
	endfunction

	// Round by the gain shift, then saturate to the sum-chain width
	function automatic logic [OUT_W-1:0] mix_round(input logic signed [MIX_W-1:0] v,
		input logic g);
		logic signed [MIX_W-1:0] t;
		t = g ? ((v + (MIX_W'(1) <<< (SH_GAIN - 1))) >>> SH_GAIN)
		      : ((v + (MIX_W'(1) <<< (SH_NOGN - 1))) >>> SH_NOGN);
		if (t > $signed(MIX_W'((1 << (OUT_W - 1)) - 1))) begin
			t = MIX_W'((1 << (OUT_W - 1)) - 1);
		end else if (t < -$signed(MIX_W'(1 << (OUT_W - 1)))) begin
			t = -$signed(MIX_W'(1 << (OUT_W - 1)));
		end
		return t[OUT_W-1:0];
	endfunction

	always_comb begin
		logic signed [MIX_W-1:0] ai;
		logic signed [MIX_W-1:0] aq;
		logic signed [MIX_W-1:0] bc;
		logic signed [MIX_W-1:0] bs;
		logic [2*DIN_W-1:0]      rd;
		ai = '0;
		aq = '0;
		bc = '0;
		bs = '0;
		rd = '0;
		r_next = r_reg;
		sy_fine  = sync_in[r_reg.ssel[SSEL_FINE +: 3]];
		sy_crs   = sync_in[r_reg.ssel[SSEL_CRS +: 3]];
		sy_nco   = sync_in[r_reg.ssel[SSEL_NCO +: 3]];
		sy_dith  = sync_in[r_reg.ssel[SSEL_DITH +: 3]];
		sy_freq  = sync_in[r_reg.ssel[SSEL_FREQ +: 3]];
		sy_phase = sync_in[r_reg.ssel[SSEL_PHASE +: 3]];
		// CDMA never runs at full rate, even before the next fine sync reloads the factor
		decim_eff = (cdma && r_reg.decim_act == 3'h0) ? 3'h1 : r_reg.decim_act;
		stat_word = '0;
		stat_word[STAT_CNT +: 3]       = r_reg.cnt;
		stat_word[STAT_WPTR +: DLY_AW] = r_reg.wptr[0];
		stat_word[STAT_ACC +: 16]      = r_reg.acc[ACC_W-1 -: 16];

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && r_reg.awready) begin
			r_next.aw_held = 1'b1;
			r_next.awready = 1'b0;
			r_next.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && r_reg.wready) begin
			r_next.w_held = 1'b1;
			r_next.wready = 1'b0;
			r_next.wdata  = s_axi_wdata;
			r_next.wstrb  = s_axi_wstrb;
		end
		if (r_reg.aw_held && r_reg.w_held && !r_reg.bvalid) begin
			r_next.bresp = RESP_OKAY;
			unique case (r_reg.awaddr)
				OFS_CTRL:    r_next.ctrl = merge_be(r_reg.ctrl, r_reg.wdata, r_reg.wstrb) & CTRL_MASK;
				OFS_FINE:    r_next.fine = merge_be(r_reg.fine, r_reg.wdata, r_reg.wstrb) & FINE_MASK;
				OFS_COARSE:  r_next.coarse = merge_be(r_reg.coarse, r_reg.wdata, r_reg.wstrb) & CRS_MASK;
				OFS_SSEL:    r_next.ssel = merge_be(r_reg.ssel, r_reg.wdata, r_reg.wstrb) & SSEL_MASK;
				OFS_FREQ_LO: r_next.freq_lo = 16'(merge_be({16'h0000, r_reg.freq_lo}, r_reg.wdata,
					r_reg.wstrb) & HALF_MASK);
				OFS_FREQ_HI: r_next.freq_hi = 16'(merge_be({16'h0000, r_reg.freq_hi}, r_reg.wdata,
					r_reg.wstrb) & HALF_MASK);
				OFS_PHASE:   r_next.pofs = 16'(merge_be({16'h0000, r_reg.pofs}, r_reg.wdata,
					r_reg.wstrb) & HALF_MASK);
				OFS_STATUS:  r_next.bresp = RESP_OKAY;
				default:     r_next.bresp = RESP_SLVERR;
			endcase
			r_next.bvalid  = 1'b1;
			r_next.aw_held = 1'b0;
			r_next.w_held  = 1'b0;
			r_next.awready = 1'b1;
			r_next.wready  = 1'b1;
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end

		// Read channel: one read in flight, address refused until data taken
		if (s_axi_arvalid && r_reg.arready) begin
			r_next.arready = 1'b0;
			r_next.rvalid  = 1'b1;
			r_next.rresp   = RESP_OKAY;
			unique case (s_axi_araddr)
				OFS_CTRL:    r_next.rdata = r_reg.ctrl;
				OFS_FINE:    r_next.rdata = r_reg.fine;
				OFS_COARSE:  r_next.rdata = r_reg.coarse;
				OFS_SSEL:    r_next.rdata = r_reg.ssel;
				OFS_FREQ_LO: r_next.rdata = {16'h0000, r_reg.freq_lo};
				OFS_FREQ_HI: r_next.rdata = {16'h0000, r_reg.freq_hi};
				OFS_PHASE:   r_next.rdata = {16'h0000, r_reg.pofs};
				OFS_STATUS:  r_next.rdata = stat_word;
				default: begin
					r_next.rdata = '0;
					r_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid  = 1'b0;
			r_next.arready = 1'b1;
		end

		// Decimation phase counter; fine sync realigns it across channels
		dec_field = r_reg.ctrl[CTRL_DECIM +: 3];
		if (sy_fine) begin
			r_next.decim_act = (cdma && dec_field == 3'h0) ? 3'h1 : dec_field;
			r_next.fine_act[0] = r_reg.fine[2:0];
			r_next.fine_act[1] = r_reg.fine[FINE_B +: 3];
			r_next.cnt = 3'h0;
		end else if (r_reg.cnt >= decim_eff) begin
			r_next.cnt = 3'h0;
		end else begin
			r_next.cnt = r_reg.cnt + 3'h1;
		end
		if (sy_crs) begin
			r_next.crs_act[0] = r_reg.coarse[5:0];
			r_next.crs_act[1] = r_reg.coarse[COARSE_B +: 6];
		end

		// Oscillator: dither below the table address, offset as a full cycle
		dither    = r_reg.ctrl[CTRL_DITH] ? r_reg.lfsr[DITH_W-1:0] : '0;
		phase_sum = r_reg.acc + {r_reg.pofs_act, 16'h0000}
			+ (ACC_W'(dither) << DITH_LSB);
		cs = cos_sin(phase_sum[ACC_W-1 -: LUT_AW]);
		bc = MIX_W'($signed(cs[2*NCO_W-1:NCO_W]));
		bs = MIX_W'($signed(cs[NCO_W-1:0]));

		r_next.out_valid = 2'b00;
		for (int p = 0; p < 2; p++) begin
			phase_sel[p] = fine_phase(decim_eff, r_reg.fine_act[p]);
			strobe[p] = (r_reg.cnt == phase_sel[p]) && (p == 0 || cdma);
			lat[p] = {1'b0, r_reg.crs_act[p]} + DLY_BASE + PAIR_EXTRA;
			if (r_reg.crs_act[p] >= CRS_NEG2) begin
				lat[p] = lat[p] - DLY_WRAP;
			end
			if (strobe[p]) begin
				rd = r_reg.mem[p][r_reg.wptr[p] - lat[p][DLY_AW-1:0]];
				r_next.mem[p][r_reg.wptr[p]] = {din_i[p], din_q[p]};
				r_next.wptr[p] = r_reg.wptr[p] + 6'h01;
				ai = MIX_W'($signed(rd[2*DIN_W-1:DIN_W]));
				aq = MIX_W'($signed(rd[DIN_W-1:0]));
				r_next.out_i[p] = mix_round(ai * bc - aq * bs, r_reg.ctrl[CTRL_GAIN]);
				r_next.out_q[p] = mix_round(ai * bs + aq * bc, r_reg.ctrl[CTRL_GAIN]);
				r_next.out_valid[p] = 1'b1;
			end
		end

		if (strobe[0]) begin
			r_next.acc  = r_reg.acc + r_reg.freq_act;
			r_next.lfsr = {r_reg.lfsr[13:0], r_reg.lfsr[14] ^ r_reg.lfsr[13]};
		end
		if (sy_nco) begin
			r_next.acc = '0;
		end
		if (sy_dith) begin
			r_next.lfsr = DITH_SEED;
		end
		if (sy_freq) begin
			r_next.freq_act = {r_reg.freq_hi, r_reg.freq_lo};
		end
		if (sy_phase) begin
			r_next.pofs_act = r_reg.pofs;
		end
	end

	// State clears apart from the readies, ctrl and lfsr, so unwritten delay words read as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg         <= '0;
			r_reg.awready <= 1'b1;
			r_reg.wready  <= 1'b1;
			r_reg.arready <= 1'b1;
			r_reg.ctrl    <= CTRL_RST;
			r_reg.lfsr    <= DITH_SEED;
		end else begin
			r_reg <= r_next;
		end
	end

	assign s_axi_awready = r_reg.awready;
	assign s_axi_wready  = r_reg.wready;
	assign s_axi_bresp   = r_reg.bresp;
	assign s_axi_bvalid  = r_reg.bvalid;
	assign s_axi_arready = r_reg.arready;
	assign s_axi_rdata   = r_reg.rdata;
	assign s_axi_rresp   = r_reg.rresp;
	assign s_axi_rvalid  = r_reg.rvalid;
	assign out_i_a       = r_reg.out_i[0];
	assign out_q_a       = r_reg.out_q[0];
	assign out_valid_a   = r_reg.out_valid[0];
	assign out_i_b       = r_reg.out_i[1];
	assign out_q_b       = r_reg.out_q[1];
	assign out_valid_b   = r_reg.out_valid[1];

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_acc_zero;
		(r_reg.acc == '0) ##1 1'b1;
	endsequence

	a_fine_four: assert property ((r_reg.decim_act == 3'h3 && r_reg.fine_act[0] == 3'h3)
		|-> phase_sel[0] == 3'h1) else $error("fine 3 at factor 4 not +1");
	a_fine_eight: assert property ((r_reg.decim_act == 3'h7 && r_reg.fine_act[0] == 3'h2)
		|-> phase_sel[0] == 3'h6) else $error("fine 2 at factor 8 not -2");
	a_coarse_neg: assert property ((r_reg.crs_act[0] == 6'h3F)
		|-> lat[0] == 7'h02 + PAIR_EXTRA) else $error("coarse 63 not -1");
	a_wptr_step: assert property (out_valid_a |-> r_reg.wptr[0] == $past(r_reg.wptr[0]) + 6'h01)
		else $error("write pointer did not step");
	a_cnt_wrap: assert property ((r_reg.cnt == decim_eff && !sy_fine) |=> r_reg.cnt == 3'h0)
		else $error("decimation counter did not wrap");
	a_cdma_rate: assert property (out_valid_a && cdma && $past(cdma) && $stable(r_reg.decim_act)
		|=> !out_valid_a)
		else $error("cdma output faster than half clock");
	a_acc_reset: assert property (sy_nco |=> s_acc_zero)
		else $error("accumulator reset sync ignored");
	a_nco_step: assert property ((strobe[0] && !sy_nco)
		|=> r_reg.acc == $past(r_reg.acc) + $past(r_reg.freq_act))
		else $error("accumulator step wrong");
	a_dither_off: assert property (!r_reg.ctrl[CTRL_DITH] |-> dither == '0)
		else $error("dither added while disabled");
	a_b_idle: assert property (!cdma |=> !out_valid_b)
		else $error("path B active outside cdma");
	a_freq_hold: assert property (!sy_freq |=> $stable(r_reg.freq_act))
		else $error("frequency changed without sync");
endmodule
`default_nettype wire

// ==== ucm_bb.sv ====
// Far-side model: interpolation filter feeding impulses, sum-chain tap counting B samples.
// Assumes the bench drives kick just after a rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none
module ucm_bb (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Stimulus request
	input  wire logic        kick,
	// Baseband to the channel
	output logic [17:0]      din_i_a,
	output logic [17:0]      din_q_a,
	output logic [17:0]      din_i_b,
	output logic [17:0]      din_q_b,
	// Sum-chain side
	input  wire logic        out_valid_b,
	output logic [15:0]      n_b
);
	// Lone impulse on I, zero elsewhere, so delay shows as the first non-zero output
	assign din_i_a = kick ? 18'h01000 : 18'h00000;
	assign din_i_b = din_i_a;
	assign din_q_a = 18'h00000;
	assign din_q_b = 18'h00000;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			n_b <= 16'h0000;
		else if (out_valid_b)
			n_b <= n_b + 16'h0001;
	end
endmodule
`default_nettype wire

// ==== duc_delay_mixer_nco_tb_top.sv ====
// Self-checking bench for the upconverter channel back end.
// Assumes the channel and the far-side model; registers driven over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module duc_delay_mixer_nco_tb_top;
	import ucm_pkg::*;
	localparam int CI = 2;
	logic aclk = 0, aresetn = 0, kick = 0;
	logic [7:0] awaddr = 0, araddr = 0, sync_in = 0;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, va, vb;
	logic [1:0] bresp, rresp, r;
	logic [17:0] dia, dqa, dib, dqb;
	logic [20:0] oia, oqa, oib, oqb;
	logic [15:0] n_b, nb0;
	logic [31:0] d, d0;
	int errors = 0, comparisons = 0, k, f;
	int fld[9] = '{3, 3, 3, 3, 7, 7, 7, 7, 1};
	int fin[9] = '{0, 1, 2, 3, 0, 1, 6, 7, 1};
	int sh[9] = '{0, -1, -2, 1, 0, -1, -6, 1, 1};
	int crs[4] = '{0, 5, 62, 63};
	int lat[4] = '{3, 8, 1, 2};
	always #2.5 aclk = ~aclk;
	ucm_chan #(.CHAN_INDEX(CI)) ucm_chan_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sync_in(sync_in), .din_i_a(dia), .din_q_a(dqa), .din_i_b(dib), .din_q_b(dqb),
		.out_i_a(oia), .out_q_a(oqa), .out_valid_a(va),
		.out_i_b(oib), .out_q_b(oqb), .out_valid_b(vb));
	ucm_bb ucm_bb_inst (.aclk(aclk), .aresetn(aresetn), .kick(kick), .din_i_a(dia),
		.din_q_a(dqa), .din_i_b(dib), .din_q_b(dqb), .out_valid_b(vb), .n_b(n_b));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Ready is a register, so its value at the falling edge is what the next rise samples
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic pa, pw, ka, kw;
		@(posedge aclk);
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1; pa = 1; pw = 1;
		while (pa || pw) begin
			@(negedge aclk);
			ka = pa && awready; kw = pw && wready;
			@(posedge aclk);
			if (ka) begin awvalid <= 0; pa = 0; end
			if (kw) begin wvalid <= 0; pw = 0; end
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge aclk);
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic t;
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do begin @(negedge aclk); t = arready; @(posedge aclk); end while (t !== 1'b1);
		arvalid <= 0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		d = rdata; r = rresp;
		@(posedge aclk);
		rready <= 0;
	endtask
	task automatic sync;
		@(posedge aclk); sync_in <= 8'h01;
		@(posedge aclk); sync_in <= 8'h00;
	endtask
	task automatic gap;
		d = 0;
		// Skip the pulse launched by the old phase at the sync edge
		@(posedge aclk);
		do @(negedge aclk); while (va !== 1'b1);
		do begin @(negedge aclk); d++; end while (va !== 1'b1 && d < 64);
	endtask
	task automatic close_out;
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		rd(OFS_CTRL); chk(d, CTRL_RST);
		rd(8'h20); chk({d[31:2], r}, {30'h0, RESP_SLVERR});
		wr(8'h24, 32'hFFFFFFFF); chk(r, RESP_SLVERR);
		wr(OFS_FINE, 32'hFFFFFFFF); rd(OFS_FINE); chk(d, FINE_MASK);
		wr(OFS_FREQ_LO, 32'h12345678); wr(OFS_FREQ_HI, 32'h00000000);
		rd(OFS_FREQ_LO); chk(d, 32'h00005678);
		wr(OFS_FINE, 32'h0);
		$display("registers done");
		foreach (crs[i]) begin
			f = (i & 1) ? 7 : 0;
			wr(OFS_CTRL, CTRL_RST | (f << CTRL_DECIM)); sync(); gap();
			chk(d, f + 1);
		end
		$display("decimation done");
		foreach (fld[i]) begin
			f = fld[i] + 1;
			wr(OFS_CTRL, CTRL_RST | (fld[i] << CTRL_DECIM)); wr(OFS_FINE, fin[i]);
			sync(); k = 0;
			@(posedge aclk);
			do begin @(negedge aclk); k++; end while (va !== 1'b1 && k < 64);
			if (fin[i] == 0) d0 = k;
			chk((k - d0 + 16) % f, (sh[i] + 16) % f);
		end
		$display("fine offset done");
		// Factor 1 with fine 0 only, so each clock is an output sample
		wr(OFS_CTRL, CTRL_RST); wr(OFS_FINE, 32'h0);
		foreach (crs[i]) begin
			wr(OFS_COARSE, crs[i]); sync();
			repeat (80) @(posedge aclk);
			kick <= 1;
			@(posedge aclk); kick <= 0;
			k = 0;
			do begin @(negedge aclk); k++; end while (oia === 21'h0 && k < 200);
			chk(k, lat[i] + 1 + CI);
		end
		$display("coarse delay done");
		chk(n_b, 16'h0000);
		wr(OFS_CTRL, CTRL_RST | 32'h1); sync(); gap();
		chk(d, 32'h2);
		nb0 = n_b;
		repeat (40) @(posedge aclk);
		chk(n_b - nb0 > 16'h0, 1'b1);
		$display("cdma done");
		close_out();
	end
endmodule
`default_nettype wire
